//--- crh_coef_read.v
`timescale 1ns/100ps
`include "crh_regs.vh"

module crh_coef_read #(
  parameter [7:0] DEV_ADDR_RESET = 8'h01
) (
  // Clock and reset.
  input wire clk_sys_i,
  input wire nrst_i,
  // Received bytes from the framing layer.
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_end_i,
  // Response bytes to the framing layer.
  output wire [7:0] tx_data_o,
  output wire tx_valid_o,
  output wire tx_last_o,
  input wire tx_ready_i,
  // Raw measurements in single-precision float.
  input wire [31:0] raw_p1_i,
  input wire [31:0] raw_p2_i,
  input wire [31:0] raw_ch0_i,
  input wire [31:0] raw_t_i,
  input wire [31:0] raw_sensor1_temperature_channel_i,
  input wire [31:0] raw_sensor2_temperature_channel_i,
  // Scaled measurements.
  output wire [31:0] scaled_p1_o,
  output wire [31:0] scaled_p2_o,
  output wire [31:0] scaled_ch0_o,
  output wire [31:0] scaled_t_o,
  output wire [31:0] scaled_sensor1_temperature_channel_o,
  output wire [31:0] scaled_sensor2_temperature_channel_o,
  // Register port.
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [31:0] reg_rdata_o
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEND = 4'h2;
  localparam [3:0] ST_CRCH = 4'h4;
  localparam [3:0] ST_CRCL = 4'h8;

  // One CRC16 step over a byte, reflected polynomial.
  function [15:0] crc_step;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc ^ {8'h00, data};
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0]) begin
          c = (c >> 1) ^ `CRH_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc_step = c;
    end
  endfunction

  // Float multiply; denormals flush to zero and the result truncates.
  function [31:0] fmul;
    input [31:0] a;
    input [31:0] b;
    reg [47:0] m;
    reg [9:0] e;
    begin
      m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'd127 + {9'd0, m[47]};
      if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9] || e == 10'd0) begin
        fmul = `CRH_FLOAT_ZERO;
      end else if (e >= 10'd255) begin
        fmul = {a[31] ^ b[31], 8'hFF, 23'h000000};
      end else if (m[47]) begin
        fmul = {a[31] ^ b[31], e[7:0], m[46:24]};
      end else begin
        fmul = {a[31] ^ b[31], e[7:0], m[45:23]};
      end
    end
  endfunction

  // Float add with truncation; the larger magnitude sets the sign.
  function [31:0] fadd;
    input [31:0] a;
    input [31:0] b;
    reg [31:0] x;
    reg [31:0] y;
    reg [24:0] mx;
    reg [24:0] my;
    reg [24:0] s;
    reg [7:0] d;
    reg [8:0] e;
    integer i;
    begin
      if (a[30:0] >= b[30:0]) begin
        x = a;
        y = b;
      end else begin
        x = b;
        y = a;
      end
      d = x[30:23] - y[30:23];
      mx = {2'b01, x[22:0]};
      my = (y[30:23] == 8'h00 || d > 8'd24) ? 25'd0 : ({2'b01, y[22:0]} >> d);
      e = {1'b0, x[30:23]};
      if (x[31] == y[31]) begin
        s = mx + my;
      end else begin
        s = mx - my;
      end
      if (s[24]) begin
        s = s >> 1;
        e = e + 9'd1;
      end
      for (i = 0; i < 24; i = i + 1) begin
        if (!s[23] && s != 25'd0 && e != 9'd0) begin
          s = s << 1;
          e = e - 9'd1;
        end
      end
      if (x[30:23] == 8'h00) begin
        fadd = y;
      end else if (s == 25'd0 || e == 9'd0) begin
        fadd = `CRH_FLOAT_ZERO;
      end else if (e >= 9'd255) begin
        fadd = {x[31], 8'hFF, 23'h000000};
      end else begin
        fadd = {x[31], e[7:0], s[22:0]};
      end
    end
  endfunction

  // True for numbers that software may change only with the unlock bit.
  function is_info;
    input [6:0] n;
    begin
      is_info = (n >= `CRH_COEF_INFO_LO && n <= `CRH_COEF_INFO_HI) || n == `CRH_COEF_CAL_DATE ||
                n == `CRH_COEF_COND_VER;
    end
  endfunction

  reg [31:0] coef_q [0:127];
  reg [2:0] ctrl_q;
  reg [7:0] dev_addr_q;
  reg [6:0] coef_sel_q;
  reg [31:0] answers_q;
  reg crc_err_q;
  reg [3:0] rx_cnt_q;
  reg [7:0] rx_addr_q;
  reg [7:0] rx_func_q;
  reg [7:0] rx_num_q;
  reg [7:0] last1_q;
  reg [7:0] last2_q;
  reg [15:0] crc_q;
  reg [15:0] crc_d1_q;
  reg [15:0] crc_d2_q;
  reg [3:0] state_q;
  reg [7:0] tx_buf_q [0:6];
  reg [2:0] tx_len_q;
  reg [2:0] tx_idx_q;
  reg [7:0] tx_data_q;
  reg [15:0] tx_crc_q;
  reg [31:0] scaled_q [0:5];
  reg [2:0] scale_idx_q;
  wire [15:0] tx_crc_next;
  wire frame_ok;
  wire for_us;
  wire take;
  wire [7:0] exc_code;
  wire [31:0] value;
  wire bus_write;
  integer k;

  // A frame is judged only once CRC and address agree, so noise never gets an answer.
  assign frame_ok = (rx_cnt_q >= 4'd4) && (crc_d2_q == {last2_q, last1_q});
  assign for_us = (rx_addr_q == dev_addr_q) || (rx_addr_q == `CRH_ADDR_TRANSPARENT);
  assign take = rx_end_i && (state_q == ST_IDLE) && frame_ok && for_us && rx_func_q == `CRH_FUNC_READ_COEF;

  // Exception priority: length first, then power-up, then number range.
  assign exc_code = (rx_cnt_q != `CRH_REQ_LEN) ? `CRH_EXC_BAD_LENGTH :
                    !ctrl_q[`CRH_CTRL_INIT_DONE] ? `CRH_EXC_NOT_INIT :
                    (rx_num_q > `CRH_NUM_MAX) ? `CRH_EXC_BAD_NUMBER : 8'h00;
  assign value = coef_q[rx_num_q[6:0]];
  assign tx_crc_next = crc_step(tx_crc_q, tx_data_q);

  // Receive side: keeps header bytes and the CRC lagging two bytes behind.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_cnt_q <= 4'h0;
      rx_addr_q <= 8'h00;
      rx_func_q <= 8'h00;
      rx_num_q <= 8'h00;
      last1_q <= 8'h00;
      last2_q <= 8'h00;
      crc_q <= `CRH_CRC_INIT;
      crc_d1_q <= `CRH_CRC_INIT;
      crc_d2_q <= `CRH_CRC_INIT;
    end else if (rx_end_i) begin
      rx_cnt_q <= 4'h0;
      crc_q <= `CRH_CRC_INIT;
      crc_d1_q <= `CRH_CRC_INIT;
      crc_d2_q <= `CRH_CRC_INIT;
    end else if (rx_valid_i) begin
      if (rx_cnt_q != 4'hF) begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      if (rx_cnt_q == 4'h0) begin
        rx_addr_q <= rx_data_i;
      end
      if (rx_cnt_q == 4'h1) begin
        rx_func_q <= rx_data_i;
      end
      if (rx_cnt_q == 4'h2) begin
        rx_num_q <= rx_data_i;
      end
      // CRC high byte arrives before the low byte, so compare against the lagged sum.
      crc_d2_q <= crc_d1_q;
      crc_d1_q <= crc_q;
      crc_q <= crc_step(crc_q, rx_data_i);
      last2_q <= last1_q;
      last1_q <= rx_data_i;
    end
  end

  // Sticky CRC error flag; a failing frame end wins over a clear in the same cycle, so no error is lost.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_err_q <= 1'b0;
    end else if (rx_end_i && rx_cnt_q >= 4'd4 && !frame_ok) begin
      crc_err_q <= 1'b1;
    end else if (bus_write && reg_addr_i == `CRH_REG_STATUS && reg_wdata_i[`CRH_STAT_CRC_ERR]) begin
      crc_err_q <= 1'b0;
    end
  end

  // Transmit side: the buffer holds the body and the CRC follows high byte first.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      tx_len_q <= 3'd0;
      tx_idx_q <= 3'd0;
      tx_data_q <= 8'h00;
      tx_crc_q <= `CRH_CRC_INIT;
      answers_q <= 32'h00000000;
      for (k = 0; k < 7; k = k + 1) begin
        tx_buf_q[k] <= 8'h00;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_SEND;
            tx_idx_q <= 3'd0;
            tx_crc_q <= `CRH_CRC_INIT;
            tx_data_q <= rx_addr_q;
            answers_q <= answers_q + 32'h00000001;
            tx_buf_q[0] <= rx_addr_q;
            if (exc_code != 8'h00) begin
              tx_len_q <= 3'd3;
              tx_buf_q[1] <= rx_func_q | `CRH_EXC_FLAG;
              tx_buf_q[2] <= exc_code;
            end else begin
              tx_len_q <= 3'd6;
              tx_buf_q[1] <= rx_func_q;
              tx_buf_q[2] <= value[31:24];
              tx_buf_q[3] <= value[23:16];
              tx_buf_q[4] <= value[15:8];
              tx_buf_q[5] <= value[7:0];
            end
          end
        end
        ST_SEND: begin
          if (tx_ready_i) begin
            tx_crc_q <= tx_crc_next;
            tx_idx_q <= tx_idx_q + 3'd1;
            if (tx_idx_q + 3'd1 == tx_len_q) begin
              state_q <= ST_CRCH;
              tx_data_q <= tx_crc_next[15:8];
            end else begin
              tx_data_q <= tx_buf_q[tx_idx_q + 3'd1];
            end
          end
        end
        ST_CRCH: begin
          if (tx_ready_i) begin
            state_q <= ST_CRCL;
            tx_data_q <= tx_crc_q[7:0];
          end
        end
        ST_CRCL: begin
          if (tx_ready_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign tx_data_o = tx_data_q;
  assign tx_valid_o = (state_q != ST_IDLE);
  assign tx_last_o = (state_q == ST_CRCL);

  // Scaler visits one channel per cycle; the offset lookup follows the firmware variant.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scale_idx_q <= 3'd0;
      for (k = 0; k < 6; k = k + 1) begin
        scaled_q[k] <= `CRH_FLOAT_ZERO;
      end
    end else begin
      scale_idx_q <= (scale_idx_q == 3'd5) ? 3'd0 : scale_idx_q + 3'd1;
      case (scale_idx_q)
        3'd0: scaled_q[0] <= fadd(fmul(raw_p1_i, coef_q[`CRH_COEF_P1_GAIN]), coef_q[`CRH_COEF_P1_OFS]);
        3'd1: scaled_q[1] <= fadd(fmul(raw_p2_i, coef_q[`CRH_COEF_P2_GAIN]), coef_q[`CRH_COEF_P2_OFS]);
        3'd2: scaled_q[2] <= fadd(fmul(raw_ch0_i, coef_q[`CRH_COEF_CH0_GAIN]), coef_q[`CRH_COEF_CH0_OFS]);
        // Earlier variant stores thresholds in these slots, so no offset is added there.
        3'd3: scaled_q[3] <= ctrl_q[`CRH_CTRL_LATER_VARIANT] ?
                             fadd(raw_t_i, coef_q[`CRH_COEF_T_OFS]) : raw_t_i;
        3'd4: scaled_q[4] <= ctrl_q[`CRH_CTRL_LATER_VARIANT] ?
                             fadd(raw_sensor1_temperature_channel_i, coef_q[`CRH_COEF_SENSOR1_TEMPERATURE_CHANNEL_OFS]) : raw_sensor1_temperature_channel_i;
        3'd5: scaled_q[5] <= ctrl_q[`CRH_CTRL_LATER_VARIANT] ?
                             fadd(raw_sensor2_temperature_channel_i, coef_q[`CRH_COEF_SENSOR2_TEMPERATURE_CHANNEL_OFS]) : raw_sensor2_temperature_channel_i;
        default: scaled_q[0] <= scaled_q[0];
      endcase
    end
  end

  assign scaled_p1_o = scaled_q[0];
  assign scaled_p2_o = scaled_q[1];
  assign scaled_ch0_o = scaled_q[2];
  assign scaled_t_o = scaled_q[3];
  assign scaled_sensor1_temperature_channel_o = scaled_q[4];
  assign scaled_sensor2_temperature_channel_o = scaled_q[5];

  assign bus_write = reg_we_i;

  // Control registers; init flag starts clear so the first reads after power-up fail.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= 3'b000;
      dev_addr_q <= DEV_ADDR_RESET;
      coef_sel_q <= 7'h00;
    end else if (bus_write) begin
      if (reg_addr_i == `CRH_REG_CTRL) begin
        ctrl_q <= reg_wdata_i[2:0];
      end
      if (reg_addr_i == `CRH_REG_DEV_ADDR) begin
        dev_addr_q <= reg_wdata_i[7:0];
      end
      if (reg_addr_i == `CRH_REG_COEF_SEL) begin
        coef_sel_q <= reg_wdata_i[6:0];
      end
    end
  end

  // Coefficient store; information entries change only while unlocked for factory loading.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (k = 0; k < 128; k = k + 1) begin
        coef_q[k] <= `CRH_FLOAT_ZERO;
      end
      coef_q[`CRH_COEF_P1_GAIN] <= `CRH_FLOAT_ONE;
      coef_q[`CRH_COEF_P2_GAIN] <= `CRH_FLOAT_ONE;
      coef_q[`CRH_COEF_CH0_GAIN] <= `CRH_FLOAT_ONE;
      coef_q[`CRH_COEF_COND_TC] <= `CRH_COND_TC_DEFAULT;
      coef_q[`CRH_COEF_COND_CELL] <= `CRH_FLOAT_ONE;
    end else if (bus_write) begin
      if (reg_addr_i == `CRH_REG_COEF_DATA &&
          (!is_info(coef_sel_q) || ctrl_q[`CRH_CTRL_INFO_UNLOCK])) begin
        coef_q[coef_sel_q] <= reg_wdata_i;
      end
      // Date word already carries year, month and day in the reply byte order.
      if (reg_addr_i == `CRH_REG_CAL_DATE && ctrl_q[`CRH_CTRL_INFO_UNLOCK]) begin
        coef_q[`CRH_COEF_CAL_DATE] <= {reg_wdata_i[31:16], reg_wdata_i[15:8], reg_wdata_i[7:0]};
      end
    end
  end

  // Read data stands for one cycle after the strobe, zero otherwise and for unmapped offsets.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `CRH_REG_CTRL: reg_rdata_o <= {29'd0, ctrl_q};
        `CRH_REG_STATUS: reg_rdata_o <= {29'd0, crc_err_q,
          !coef_q[`CRH_COEF_SQRT_THR][31] && coef_q[`CRH_COEF_SQRT_THR][30:0] != 31'd0,
          state_q != ST_IDLE};
        `CRH_REG_DEV_ADDR: reg_rdata_o <= {24'd0, dev_addr_q};
        `CRH_REG_COEF_SEL: reg_rdata_o <= {25'd0, coef_sel_q};
        `CRH_REG_COEF_DATA: reg_rdata_o <= coef_q[coef_sel_q];
        `CRH_REG_CAL_DATE: reg_rdata_o <= coef_q[`CRH_COEF_CAL_DATE];
        `CRH_REG_ANSWERS: reg_rdata_o <= answers_q;
        default: begin
          if (reg_addr_i >= `CRH_REG_SCALED_BASE && reg_addr_i <= `CRH_REG_SCALED_LAST &&
              reg_addr_i[1:0] == 2'b00) begin
            reg_rdata_o <= scaled_q[reg_addr_i[4:2] - 3'd0];
          end else begin
            reg_rdata_o <= 32'h00000000;
          end
        end
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule

//--- crh_regs.vh
`ifndef CRH_REGS_VH
`define CRH_REGS_VH

// Bus frame constants.
`define CRH_FUNC_READ_COEF 8'h1E
`define CRH_FUNC_INIT 8'h30
`define CRH_ADDR_TRANSPARENT 8'hFA
`define CRH_EXC_FLAG 8'h80
`define CRH_EXC_BAD_NUMBER 8'h02
`define CRH_EXC_BAD_LENGTH 8'h03
`define CRH_EXC_NOT_INIT 8'h20
`define CRH_REQ_LEN 4'h5
`define CRH_NUM_MAX 8'h6F
`define CRH_CRC_INIT 16'hFFFF
`define CRH_CRC_POLY 16'hA001

// Coefficient numbers.
`define CRH_COEF_SQRT_THR 7'h35
`define CRH_COEF_P1_OFS 7'h40
`define CRH_COEF_P1_GAIN 7'h41
`define CRH_COEF_P2_OFS 7'h42
`define CRH_COEF_P2_GAIN 7'h43
`define CRH_COEF_AO_OFS 7'h44
`define CRH_COEF_AO_GAIN 7'h45
`define CRH_COEF_CH0_OFS 7'h46
`define CRH_COEF_CH0_GAIN 7'h47
`define CRH_COEF_T_OFS 7'h48
`define CRH_COEF_SENSOR1_TEMPERATURE_CHANNEL_OFS 7'h4A
`define CRH_COEF_SENSOR2_TEMPERATURE_CHANNEL_OFS 7'h4C
`define CRH_COEF_INFO_LO 7'h50
`define CRH_COEF_INFO_HI 7'h5F
`define CRH_COEF_CAL_DATE 7'h63
`define CRH_COEF_COND_VER 7'h78
`define CRH_COEF_COND_TC 7'h7E
`define CRH_COEF_COND_CELL 7'h7F

// Reset values of coefficients.
`define CRH_FLOAT_ONE 32'h3F800000
`define CRH_FLOAT_ZERO 32'h00000000
`define CRH_COND_TC_DEFAULT 32'h3CB43958

// Register offsets.
`define CRH_REG_CTRL 8'h00
`define CRH_REG_STATUS 8'h04
`define CRH_REG_DEV_ADDR 8'h08
`define CRH_REG_COEF_SEL 8'h0C
`define CRH_REG_COEF_DATA 8'h10
`define CRH_REG_CAL_DATE 8'h14
`define CRH_REG_ANSWERS 8'h18
`define CRH_REG_SCALED_BASE 8'h20
`define CRH_REG_SCALED_LAST 8'h34

// Control and status bits.
`define CRH_CTRL_INIT_DONE 0
`define CRH_CTRL_LATER_VARIANT 1
`define CRH_CTRL_INFO_UNLOCK 2
`define CRH_STAT_BUSY 0
`define CRH_STAT_SQRT_OK 1
`define CRH_STAT_CRC_ERR 2

`endif

//--- crh_coef_read_asserts.sv
`timescale 1ns/100ps
module crh_coef_read_asserts (
  // Clock and reset.
  input wire clk_sys_i,
  input wire nrst_i,
  // Request bytes.
  input wire [7:0] rx_data_i,
  input wire rx_valid_i,
  input wire rx_end_i,
  // Response bytes.
  input wire [7:0] tx_data_o,
  input wire tx_valid_o,
  input wire tx_last_o,
  input wire tx_ready_i
);
  logic [3:0] tx_cnt_q;
  logic exc_q;
  logic [7:0] addr_q;
  logic rx_first_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Position in the answer, its kind, and the address of the request that caused it.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_cnt_q <= 4'h0;
      exc_q <= 1'b0;
      addr_q <= 8'h00;
      rx_first_q <= 1'b1;
    end else begin
      if (tx_valid_o && tx_ready_i) begin
        tx_cnt_q <= tx_last_o ? 4'h0 : tx_cnt_q + 4'h1;
      end
      if (tx_valid_o && tx_ready_i && tx_cnt_q == 4'h1) begin
        exc_q <= tx_data_o[7];
      end
      if (rx_valid_i && rx_first_q) begin
        addr_q <= rx_data_i;
      end
      if (rx_valid_i) begin
        rx_first_q <= 1'b0;
      end else if (rx_end_i) begin
        rx_first_q <= 1'b1;
      end
    end
  end

  a_byte_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("Response byte changed before it was accepted.");
  a_last_ends: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
    else $error("Response continued after the final byte.");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o)
    else $error("Last flag without a valid byte.");
  a_frame_len: assert property (tx_valid_o && tx_last_o |-> tx_cnt_q == (exc_q ? 4'h4 : 4'h7))
    else $error("Response frame has the wrong length.");
  a_func_echo: assert property (tx_valid_o && tx_cnt_q == 4'h1 |-> tx_data_o == 8'h1E || tx_data_o == 8'h9E)
    else $error("Second response byte is not the read function.");
  a_exc_code: assert property (tx_valid_o && exc_q && tx_cnt_q == 4'h2 |-> tx_data_o inside {8'h02, 8'h03, 8'h20})
    else $error("Exception code outside the allowed set.");
  a_answer_cause: assert property ($rose(tx_valid_o) |-> $past(rx_end_i))
    else $error("Answer started without a finished request.");
  a_addr_echo: assert property ($rose(tx_valid_o) |-> tx_data_o == addr_q)
    else $error("Answer does not start with the request address.");

  c_value: cover property (tx_valid_o && tx_ready_i && tx_last_o && !exc_q);
  c_exc: cover property (tx_valid_o && tx_ready_i && tx_last_o && exc_q);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule

bind crh_coef_read crh_coef_read_asserts u_chk (
  .clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i),
  .rx_data_i(rx_data_i),
  .rx_valid_i(rx_valid_i),
  .rx_end_i(rx_end_i),
  .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o),
  .tx_last_o(tx_last_o),
  .tx_ready_i(tx_ready_i)
);

//--- crh_master_model.sv
`timescale 1ns/100ps
module crh_master_model (
  // Clock.
  input wire clk_sys_i,
  // Request side.
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  // Response side.
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  input wire tx_last_i,
  output logic tx_ready_o
);
  // Idle values; the data line never rests on a stale byte.
  initial begin
    rx_data_o = 8'hA5;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // Reflected CRC16 over the frame body, start value all ones.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  // Sends one request and collects the answer; stall holds ready low between bytes.
  task automatic xfer(input logic [7:0] body[$], input bit bad_crc, input int stall, output logic [7:0] resp[$]);
    logic [7:0] f[$];
    logic [15:0] c;
    int k;
    bit done;
    c = crc16(body) ^ {15'h0000, bad_crc};
    f = body;
    f.push_back(c[15:8]);
    f.push_back(c[7:0]);
    resp = {};
    foreach (f[i]) begin
      @(posedge clk_sys_i);
      rx_data_o <= f[i];
      rx_valid_o <= 1'b1;
    end
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_end_o <= 1'b1;
    rx_data_o <= ~f[f.size() - 1];
    @(posedge clk_sys_i);
    rx_end_o <= 1'b0;
    tx_ready_o <= (stall == 0);
    done = 1'b0;
    k = 0;
    // A refused request gets no answer, so the wait is bounded.
    while (!done && k < 100) begin
      @(negedge clk_sys_i);
      if (tx_valid_i && tx_ready_o) begin
        resp.push_back(tx_data_i);
        done = tx_last_i;
      end
      @(posedge clk_sys_i);
      k++;
      tx_ready_o <= !done && ((stall == 0) || (k % (stall + 1) == 0));
    end
  endtask
endmodule

//--- tb_crh_coef_read.sv
`timescale 1ns/100ps
`include "crh_regs.vh"
module tb_crh_coef_read;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  wire [7:0] rx_data;
  wire rx_valid;
  wire rx_end;
  wire tx_ready;
  wire [7:0] tx_data;
  wire tx_valid;
  wire tx_last;
  logic [31:0] raw [6];
  wire [31:0] scaled [6];
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  wire [31:0] reg_rdata;
  int n_fail = 0;
  int checks_done = 0;
  logic [7:0] resp[$];

  // 125 MHz system clock.
  always #4 clk_sys_i = ~clk_sys_i;

  crh_coef_read DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_end_i(rx_end), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
    .raw_p1_i(raw[0]), .raw_p2_i(raw[1]), .raw_ch0_i(raw[2]), .raw_t_i(raw[3]), .raw_sensor1_temperature_channel_i(raw[4]),
    .raw_sensor2_temperature_channel_i(raw[5]), .scaled_p1_o(scaled[0]), .scaled_p2_o(scaled[1]), .scaled_ch0_o(scaled[2]),
    .scaled_t_o(scaled[3]), .scaled_sensor1_temperature_channel_o(scaled[4]), .scaled_sensor2_temperature_channel_o(scaled[5]), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(reg_rdata));

  crh_master_model u_mst (.clk_sys_i(clk_sys_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_end_o(rx_end),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_last_i(tx_last), .tx_ready_o(tx_ready));

  task automatic stop_test;
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Compares the collected answer with a body plus its own checksum.
  task automatic chk_frame(input string name, input logic [7:0] exp[$]);
    logic [15:0] c;
    c = u_mst.crc16(exp);
    exp.push_back(c[15:8]);
    exp.push_back(c[7:0]);
    chk(name, exp.size(), resp.size());
    foreach (exp[i]) if (i < resp.size()) chk(name, exp[i], resp[i]);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys_i);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys_i);
    reg_re <= 1'b0;
    @(negedge clk_sys_i);
    chk(name, exp, reg_rdata);
  endtask

  task automatic coef(input logic [7:0] n, input logic [31:0] d);
    wr(`CRH_REG_COEF_SEL, n);
    wr(`CRH_REG_COEF_DATA, d);
  endtask

  task automatic exp_val(input string name, input logic [7:0] a, n, input int stall, input logic [31:0] v);
    u_mst.xfer({a, 8'h1E, n}, 1'b0, stall, resp);
    chk_frame(name, {a, 8'h1E, v[31:24], v[23:16], v[15:8], v[7:0]});
  endtask

  task automatic exp_exc(input string name, input logic [7:0] body[$], input logic [7:0] code);
    u_mst.xfer(body, 1'b0, 0, resp);
    chk_frame(name, {body[0], body[1] | 8'h80, code});
  endtask

  task automatic t_not_init;
    exp_exc("uninit", {8'h01, 8'h1E, 8'h40}, 8'h20);
    exp_exc("length", {8'h01, 8'h1E, 8'h40, 8'h00}, 8'h03);
  endtask

  task automatic t_defaults;
    logic [31:0] dv [8];
    dv = '{32'h00000000, `CRH_FLOAT_ONE, 32'h00000000, `CRH_FLOAT_ONE, 32'h00000000, 32'h00000000,
      32'h00000000, `CRH_FLOAT_ONE};
    wr(`CRH_REG_CTRL, 32'h00000001);
    for (int i = 0; i < 8; i++) begin
      exp_val("default", 8'h01, 8'(64 + i), 0, dv[i]);
    end
    exp_val("analogue range", 8'h01, 8'h5C, 0, 32'h00000000);
    exp_val("transparent", 8'hFA, 8'h6F, 0, 32'h00000000);
    exp_exc("number", {8'h01, 8'h1E, 8'h70}, 8'h02);
  endtask

  task automatic t_store;
    coef(8'h64, 32'h12345678);
    exp_val("customer", 8'h01, 8'h64, 2, 32'h12345678);
    coef(8'h50, 32'h41200000);
    rd("info write", `CRH_REG_COEF_DATA, 32'h00000000);
    coef(8'h35, `CRH_FLOAT_ONE);
    rd("sqrt status", `CRH_REG_STATUS, 32'h00000002);
  endtask

  task automatic t_cal_date;
    wr(`CRH_REG_CTRL, 32'h00000005);
    wr(`CRH_REG_CAL_DATE, 32'h07E80C1F);
    exp_val("date", 8'h01, 8'h63, 1, 32'h07E80C1F);
  endtask

  task automatic t_refused;
    u_mst.xfer({8'h01, 8'h1E, 8'h40}, 1'b1, 0, resp);
    chk("bad crc answer", 32'h00000000, resp.size());
    rd("crc flag", `CRH_REG_STATUS, 32'h00000006);
    wr(`CRH_REG_STATUS, 32'h00000004);
    rd("crc clear", `CRH_REG_STATUS, 32'h00000002);
    u_mst.xfer({8'h05, 8'h1E, 8'h40}, 1'b0, 0, resp);
    chk("foreign answer", 32'h00000000, resp.size());
    rd("unmapped", 8'hFC, 32'h00000000);
  endtask

  // Gain 2.0 and offset 1.0 on the primary channel, offset 1.0 on the ambient temperature.
  task automatic t_scaling;
    wr(`CRH_REG_CTRL, 32'h00000003);
    coef(8'h41, 32'h40000000);
    coef(8'h40, `CRH_FLOAT_ONE);
    coef(8'h48, `CRH_FLOAT_ONE);
    coef(8'h49, 32'h40000000);
    @(posedge clk_sys_i);
    raw[0] <= 32'h40400000;
    raw[3] <= 32'h40000000;
    repeat (14) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("scaled p1", 32'h40E00000, scaled[0]);
    chk("scaled t", 32'h40400000, scaled[3]);
    foreach (raw[i]) if (i != 0 && i != 3) chk("scaled default", raw[i], scaled[i]);
    exp_val("temp offset", 8'h01, 8'h48, 0, `CRH_FLOAT_ONE);
    rd("scaled reg", `CRH_REG_SCALED_BASE, 32'h40E00000);
    coef(8'h45, 32'h40000000);
    exp_val("ao gain", 8'h01, 8'h45, 1, 32'h40000000);
    wr(`CRH_REG_CTRL, 32'h00000001);
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("earlier t", 32'h40000000, scaled[3]);
  endtask

  // Main sequence; the last check ends the run.
  initial begin
    foreach (raw[i]) raw[i] = 32'h40000000 + (i << 20);
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_not_init;
    t_defaults;
    t_store;
    t_cal_date;
    t_refused;
    t_scaling;
    stop_test;
  end

  // Watchdog sized well above the several hundred cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    stop_test;
  end
endmodule
